//--- design/uasir_pkg.sv
// constants for the usb application status and interrupt register bank
// assumes an 8-bit core clocked by clk, one instruction per clock
package uasir_pkg;
   // ========================================
   // register numbers in the special register space
   localparam logic [7:0] ADDR_SUPPLY_DIP  = 8'h0a;
   localparam logic [7:0] ADDR_EP_STATUS   = 8'h0c;
   localparam logic [7:0] ADDR_FIFO_PTR    = 8'h0d;
   localparam logic [7:0] ADDR_FIFO_DATA   = 8'h0e;
   localparam logic [7:0] ADDR_IRQ_FLAGS   = 8'h0f;
   // ========================================
   // field positions
   localparam int DIP_BIT     = 4;
   localparam int EPS_STALL   = 0;
   localparam int EPS_BUSY    = 1;
   localparam int EPS_HSUSP   = 2;
   localparam int EPS_EP2RX   = 3;
   localparam int EPS_EP0TX   = 4;
   localparam int EPS_EP2TX   = 6;
   localparam int EPS_CTRLRX  = 7;
   localparam int IF_TMR      = 0;
   localparam int IF_CTRL     = 1;
   localparam int IF_SUSP     = 2;
   localparam int IF_BRST     = 3;
   localparam int IF_PIN      = 4;
   localparam int IF_RESUME   = 7;
   localparam int CT_WDT_LSB  = 0;
   localparam int CT_TMR_LSB  = 3;
   localparam int CT_IRQDIS   = 6;
   localparam int CT_LED      = 7;
   localparam int PTR_BITS    = 5;
   // ========================================
   // reset values and implemented-bit masks
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [7:0] RST_CONTROL   = 8'h3f;
   localparam logic [7:0] IF_IMPL_MASK  = 8'h9f;
   localparam logic [4:0] PTR_WIN_BASE  = 5'h10;
   // ========================================
   // fifo geometry
   localparam int EP_COUNT   = 3;
   localparam int FIFO_DEPTH = 8;
   // ========================================
   // timing
   localparam int CLK_PERIOD_NS      = 10;
   localparam int SUSPEND_IDLE_NS    = 3_000_000;
   localparam int SUSPEND_IDLE_CYC   = SUSPEND_IDLE_NS / CLK_PERIOD_NS;
   localparam int WDT_BASE_NS        = 8_000_000;
   localparam int WDT_BASE_CYC       = WDT_BASE_NS / CLK_PERIOD_NS;
endpackage : uasir_pkg

//--- design/uasir_regs.sv
// usb application status, fifo window, interrupt flag and control registers
// assumes the core drives register strobes on clk; usb engine is same-clock logic
//
// How it works
// - supply dip sets flag until software clears
// - chip reset (rst_b) clears supply dip flag; usb bus reset does not
// - firmware stall bit, cleared by good setup
// - busy bit shows engine using control fifo
// - suspend bit after idle time, clears on activity
// - endpoint2 receive flag blocks further host data
// - firmware sets transmit requests, engine clears them
// - engine sets control receive flag, firmware clears
// - five bit pointer, upper bits read zero
// - data window moves byte chosen by pointer
// - timer overflow flag sticks until cleared
// - control endpoint command sets sticky flag
// - suspend and bus reset set sticky flags
// - pin change flag, qualifying pins follow mode
// - resume flag on suspend fall, dual clock
// - watchdog prescale 1:1 to 1:128
// - timer prescale 1:2 to 1:256
// - watchdog time is base times ratio
// - interrupt disable bit set/cleared by instructions
// - control bit7 enables high sink drive
// - interrupt needs mask bit and global enable
// - eight byte fifo per endpoint, pointer reached
`timescale 1ns/1ns
`default_nettype none
module uasir_regs #(
   parameter int SUSPEND_CYC = uasir_pkg::SUSPEND_IDLE_CYC,
   parameter int WDT_CYC     = uasir_pkg::WDT_BASE_CYC
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       regWr,
   input  wire logic       regRd,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   output logic      [7:0] regRdData_ff,
   input  wire logic       ctrlRegWrInstr,
   input  wire logic       ctrlRegRdInstr,
   input  wire logic       irqDisableInstr,
   input  wire logic       irqEnableInstr,
   input  wire logic       irqReturnInstr,
   input  wire logic [7:0] irqMask,
   output logic            irqReq_ff,
   input  wire logic       supplyLowPin,
   input  wire logic [3:0] port7PinsHi,
   input  wire logic       usbMode,
   input  wire logic       dualClock,
   input  wire logic       timerOverflow,
   input  wire logic       watchdogEnable,
   output logic            timerTick_ff,
   output logic            watchdogTimeout_ff,
   output logic            ledSinkEn_ff,
   input  wire logic       engSetupOk,
   input  wire logic       engBusy,
   input  wire logic       engBusActivity,
   input  wire logic       engEp2RxAccept,
   input  wire logic [2:0] engTxDone,
   input  wire logic       engCtrlRxDone,
   input  wire logic       engCtrlCmd,
   input  wire logic       engBusReset,
   input  wire logic       engWr,
   input  wire logic       engRd,
   input  wire logic [1:0] engEp,
   input  wire logic [2:0] engByte,
   input  wire logic [7:0] engWrData,
   output logic      [7:0] engRdData_ff,
   output logic            stallReq_ff,
   output logic      [2:0] txRequest_ff,
   output logic            ep2RxBlock_ff,
   output logic            ctrlRxLock_ff
);
   import uasir_pkg::*;

   // ========================================
   // helpers
   function automatic logic [4:0] fifoIdx(input logic [1:0] ep, input logic [2:0] bytePos);
      fifoIdx = {ep, bytePos};
   endfunction : fifoIdx

   logic       wrDip;
   logic       wrEps;
   logic       wrPtr;
   logic       wrData;
   logic       rdData;
   logic       wrFlags;
   assign wrDip   = regWr && (regAddr == ADDR_SUPPLY_DIP);
   assign wrEps   = regWr && (regAddr == ADDR_EP_STATUS);
   assign wrPtr   = regWr && (regAddr == ADDR_FIFO_PTR);
   assign wrData  = regWr && (regAddr == ADDR_FIFO_DATA);
   assign rdData  = regRd && (regAddr == ADDR_FIFO_DATA);
   assign wrFlags = regWr && (regAddr == ADDR_IRQ_FLAGS);

   // ========================================
   // pin synchronisers
   logic       lowMeta_ff;
   logic       lowSync_ff;
   logic       lowPrev_ff;
   logic [3:0] pinMeta_ff;
   logic [3:0] pinSync_ff;
   logic [3:0] pinPrev_ff;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lowMeta_ff <= 1'b0;
         lowSync_ff <= 1'b0;
         lowPrev_ff <= 1'b0;
         pinMeta_ff <= 4'h0;
         pinSync_ff <= 4'h0;
         pinPrev_ff <= 4'h0;
      end else begin
         lowMeta_ff <= supplyLowPin;
         lowSync_ff <= lowMeta_ff;
         lowPrev_ff <= lowSync_ff;
         pinMeta_ff <= port7PinsHi;
         pinSync_ff <= pinMeta_ff;
         pinPrev_ff <= pinSync_ff;
      end
   end

   // ========================================
   // supply dip flag
   logic dipFlag_ff;
   logic dipEvent;
   assign dipEvent = lowSync_ff && !lowPrev_ff;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dipFlag_ff <= 1'b0;
      end else if (dipEvent) begin
         dipFlag_ff <= 1'b1;
      end else if (wrDip && !regWrData[DIP_BIT]) begin
         dipFlag_ff <= 1'b0;
      end
   end

   // ========================================
   // endpoint status
   logic busy_ff;
   logic [$clog2(SUSPEND_CYC+1)-1:0] idleCnt_ff;
   logic hostSusp_ff;
   logic hostSuspPrev_ff;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stallReq_ff <= 1'b0;
      end else if (wrEps && regWrData[EPS_STALL]) begin
         stallReq_ff <= 1'b1;
      end else if (engSetupOk || (wrEps && !regWrData[EPS_STALL])) begin
         stallReq_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= engBusy;
      end
   end

   // idle counting stops at the limit so the bit holds through long suspends
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         idleCnt_ff      <= '0;
         hostSusp_ff     <= 1'b0;
         hostSuspPrev_ff <= 1'b0;
      end else begin
         hostSuspPrev_ff <= hostSusp_ff;
         if (engBusActivity) begin
            idleCnt_ff  <= '0;
            hostSusp_ff <= 1'b0;
         end else if (idleCnt_ff == ($bits(idleCnt_ff))'(SUSPEND_CYC - 1)) begin
            hostSusp_ff <= 1'b1;
         end else begin
            idleCnt_ff  <= idleCnt_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ep2RxBlock_ff <= 1'b0;
      end else if (engEp2RxAccept) begin
         ep2RxBlock_ff <= 1'b1;
      end else if (wrEps && !regWrData[EPS_EP2RX]) begin
         ep2RxBlock_ff <= 1'b0;
      end
   end

   // firmware may only set; a simultaneous set beats the engine's clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         txRequest_ff <= 3'h0;
      end else begin
         for (int i = 0; i < EP_COUNT; i++) begin
            if (wrEps && regWrData[EPS_EP0TX+i]) begin
               txRequest_ff[i] <= 1'b1;
            end else if (engTxDone[i]) begin
               txRequest_ff[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrlRxLock_ff <= 1'b0;
      end else if (engCtrlRxDone) begin
         ctrlRxLock_ff <= 1'b1;
      end else if (wrEps) begin
         ctrlRxLock_ff <= regWrData[EPS_CTRLRX];
      end
   end

   // ========================================
   // fifo space: 0x00-0x02 data, 0x10-0x12 byte pointers
   logic [7:0] fifoMem [EP_COUNT*FIFO_DEPTH];
   logic [2:0] bytePtr_ff [EP_COUNT];
   logic [PTR_BITS-1:0] fifoPtr_ff;
   logic [1:0] cpuEp;
   logic       cpuDataSel;
   logic       cpuPtrSel;
   logic [4:0] cpuIdx;
   assign cpuEp      = fifoPtr_ff[1:0];
   assign cpuDataSel = (fifoPtr_ff[4:2] == 3'h0) && (cpuEp != 2'h3);
   assign cpuPtrSel  = (fifoPtr_ff[4:2] == PTR_WIN_BASE[4:2]) && (cpuEp != 2'h3);
   assign cpuIdx     = fifoIdx(cpuEp, bytePtr_ff[cpuEp]);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fifoPtr_ff <= RST_ZERO[PTR_BITS-1:0];
      end else if (wrPtr) begin
         fifoPtr_ff <= regWrData[PTR_BITS-1:0];
      end
   end

   // byte pointers step after each data access so bytes stream out in order
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < EP_COUNT; i++) begin
            bytePtr_ff[i] <= 3'h0;
         end
      end else if (wrData && cpuPtrSel) begin
         bytePtr_ff[cpuEp] <= regWrData[2:0];
      end else if ((wrData || rdData) && cpuDataSel) begin
         bytePtr_ff[cpuEp] <= bytePtr_ff[cpuEp] + 3'h1;
      end
   end

   // engine write is dropped if it targets endpoint 3 or firmware hits the same byte in that cycle
   always_ff @(posedge clk) begin
      if (wrData && cpuDataSel) begin
         fifoMem[cpuIdx] <= regWrData;
      end
      if (engWr && (engEp != 2'h3) && !(wrData && cpuDataSel && cpuIdx == fifoIdx(engEp, engByte))) begin
         fifoMem[fifoIdx(engEp, engByte)] <= engWrData;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         engRdData_ff <= RST_ZERO;
      end else if (engRd && (engEp != 2'h3)) begin
         engRdData_ff <= fifoMem[fifoIdx(engEp, engByte)];
      end
   end

   // ========================================
   // interrupt flags
   logic [7:0] irqFlags_ff;
   logic [7:0] flagSet;
   logic [3:0] pinQual;
   assign pinQual = usbMode ? 4'hc : 4'hf;
   always_comb begin
      flagSet            = 8'h00;
      flagSet[IF_TMR]    = timerOverflow;
      flagSet[IF_CTRL]   = engCtrlCmd;
      flagSet[IF_SUSP]   = hostSusp_ff && !hostSuspPrev_ff;
      flagSet[IF_BRST]   = engBusReset;
      flagSet[IF_PIN]    = |((pinSync_ff ^ pinPrev_ff) & pinQual);
      flagSet[IF_RESUME] = dualClock && !hostSusp_ff && hostSuspPrev_ff;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irqFlags_ff <= RST_ZERO;
      end else if (wrFlags) begin
         irqFlags_ff <= ((irqFlags_ff & regWrData) | flagSet) & IF_IMPL_MASK;
      end else begin
         irqFlags_ff <= irqFlags_ff | flagSet;
      end
   end

   // ========================================
   // control register
   logic [7:0] control_ff;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         control_ff <= RST_CONTROL;
      end else begin
         if (ctrlRegWrInstr) begin
            control_ff[5:0]    <= regWrData[5:0];
            control_ff[CT_LED] <= regWrData[CT_LED];
         end
         if (irqDisableInstr) begin
            control_ff[CT_IRQDIS] <= 1'b1;
         end else if (irqEnableInstr || irqReturnInstr) begin
            control_ff[CT_IRQDIS] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ledSinkEn_ff <= 1'b0;
         irqReq_ff    <= 1'b0;
      end else begin
         ledSinkEn_ff <= control_ff[CT_LED];
         irqReq_ff    <= |(irqFlags_ff & irqMask & IF_IMPL_MASK) && !control_ff[CT_IRQDIS];
      end
   end

   // ========================================
   // prescalers
   logic [7:0] tmrDiv_ff;
   logic [7:0] tmrMask;
   logic [$clog2(WDT_CYC+1)-1:0] wdtBase_ff;
   logic [6:0] wdtDiv_ff;
   logic [6:0] wdtMask;
   assign tmrMask = 8'(9'h1ff >> (4'h8 - {1'b0, control_ff[CT_TMR_LSB +: 3]}));
   assign wdtMask = 7'(8'hff >> (4'h8 - {1'b0, control_ff[CT_WDT_LSB +: 3]}));

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tmrDiv_ff    <= 8'h00;
         timerTick_ff <= 1'b0;
      end else begin
         tmrDiv_ff    <= tmrDiv_ff + 8'h01;
         timerTick_ff <= ((tmrDiv_ff & tmrMask) == tmrMask);
      end
   end

   // base ticks every 8 ms; the divider picks how many base ticks make a timeout
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wdtBase_ff         <= '0;
         wdtDiv_ff          <= 7'h00;
         watchdogTimeout_ff <= 1'b0;
      end else if (!watchdogEnable) begin
         wdtBase_ff         <= '0;
         wdtDiv_ff          <= 7'h00;
         watchdogTimeout_ff <= 1'b0;
      end else if (wdtBase_ff == ($bits(wdtBase_ff))'(WDT_CYC - 1)) begin
         wdtBase_ff         <= '0;
         wdtDiv_ff          <= wdtDiv_ff + 7'h01;
         watchdogTimeout_ff <= ((wdtDiv_ff & wdtMask) == wdtMask);
      end else begin
         wdtBase_ff         <= wdtBase_ff + 1'b1;
         watchdogTimeout_ff <= 1'b0;
      end
   end

   // ========================================
   // register read port, one cycle latency
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         regRdData_ff <= RST_ZERO;
      end else if (ctrlRegRdInstr) begin
         regRdData_ff <= control_ff;
      end else if (regRd) begin
         unique case (regAddr)
            ADDR_SUPPLY_DIP: regRdData_ff <= {3'h0, dipFlag_ff, 4'h0};
            ADDR_EP_STATUS:  regRdData_ff <= {ctrlRxLock_ff, txRequest_ff[2], txRequest_ff[1],
                                              txRequest_ff[0], ep2RxBlock_ff, hostSusp_ff,
                                              busy_ff, stallReq_ff};
            ADDR_FIFO_PTR:   regRdData_ff <= {3'h0, fifoPtr_ff};
            ADDR_FIFO_DATA:  regRdData_ff <= cpuDataSel ? fifoMem[cpuIdx] :
                                             cpuPtrSel ? {5'h00, bytePtr_ff[cpuEp]} : 8'h00;
            ADDR_IRQ_FLAGS:  regRdData_ff <= irqFlags_ff;
            default:         regRdData_ff <= 8'h00;
         endcase
      end
   end

   // ========================================
   // checks
   chk_dip_sets: assert property (@(posedge clk) disable iff (!rst_b)
      dipEvent |=> dipFlag_ff) else $error("dip flag not set");
   chk_stall_hwclr: assert property (@(posedge clk) disable iff (!rst_b)
      engSetupOk && !wrEps |=> !stallReq_ff) else $error("stall not cleared");
   chk_tx_clear: assert property (@(posedge clk) disable iff (!rst_b)
      engTxDone[0] && !wrEps |=> !txRequest_ff[0]) else $error("tx request kept");
   chk_ctrlrx_set: assert property (@(posedge clk) disable iff (!rst_b)
      engCtrlRxDone |=> ctrlRxLock_ff) else $error("ctrl rx not set");
   chk_ptr_upper: assert property (@(posedge clk) disable iff (!rst_b)
      regRd && regAddr == ADDR_FIFO_PTR |=> regRdData_ff[7:5] == 3'h0)
      else $error("pointer upper bits");
   chk_suspend_act: assert property (@(posedge clk) disable iff (!rst_b)
      engBusActivity |=> !hostSusp_ff ##1 !hostSusp_ff) else $error("suspend on activity");
   chk_flag_setwins: assert property (@(posedge clk) disable iff (!rst_b)
      timerOverflow && wrFlags |=> irqFlags_ff[IF_TMR]) else $error("set lost to clear");
   chk_irq_gate: assert property (@(posedge clk) disable iff (!rst_b)
      control_ff[CT_IRQDIS] |=> !irqReq_ff) else $error("irq while disabled");
   chk_disable_instr: assert property (@(posedge clk) disable iff (!rst_b)
      irqDisableInstr |=> control_ff[CT_IRQDIS] ##1 !irqReq_ff) else $error("disable failed");
   chk_led_follow: assert property (@(posedge clk) disable iff (!rst_b)
      ctrlRegWrInstr |=> ##1 ledSinkEn_ff == $past(regWrData[CT_LED], 2))
      else $error("led sink mismatch");
   cov_dip: cover property (@(posedge clk) disable iff (!rst_b) dipEvent ##1 wrDip);
   cov_suspend: cover property (@(posedge clk) disable iff (!rst_b) $rose(hostSusp_ff));
   cov_irq: cover property (@(posedge clk) disable iff (!rst_b) $rose(irqReq_ff));
   cov_fifo: cover property (@(posedge clk) disable iff (!rst_b) wrData && cpuDataSel ##1 rdData);
endmodule : uasir_regs
`default_nettype wire

//--- test/uasir_eng_model.sv
// usb engine stand-in: fifo writes, transmit service, bus events
// assumes the bank shares clk; tasks are entered just after an edge
`timescale 1ns/1ns
`default_nettype none
module uasir_eng_model (
   input  wire logic       clk,
   input  wire logic       ctrlRxLock_ff,
   input  wire logic       ep2RxBlock_ff,
   input  wire logic [2:0] txRequest_ff,
   output logic            engSetupOk,
   output logic            engBusy,
   output logic            engBusActivity,
   output logic            engEp2RxAccept,
   output logic      [2:0] engTxDone,
   output logic            engCtrlRxDone,
   output logic            engCtrlCmd,
   output logic            engBusReset,
   output logic            engWr,
   output logic            engRd,
   output logic      [1:0] engEp,
   output logic      [2:0] engByte,
   output logic      [7:0] engWrData
);
   initial begin
      {engSetupOk, engBusy, engBusActivity, engEp2RxAccept, engTxDone, engCtrlRxDone} = '0;
      {engCtrlCmd, engBusReset, engWr, engRd, engEp, engByte} = '0;
      engWrData = 8'h5a;
   end
   // one-cycle event: 0 setup ok, 1 bus activity, 2 ctrl command, 3 bus reset
   task ev(input int k);
      {engBusReset, engCtrlCmd, engBusActivity, engSetupOk} = 4'h1 << k;
      @(posedge clk) #1;
      {engBusReset, engCtrlCmd, engBusActivity, engSetupOk} = 4'h0;
   endtask : ev
   // host data for ep0 or ep2; dropped while the bank keeps it locked
   task put(input logic [1:0] ep, input logic [2:0] b, input logic [7:0] d);
      if (!(ep == 2'h0 ? ctrlRxLock_ff : ep2RxBlock_ff)) begin
         {engBusy, engWr, engEp, engByte, engWrData} = {ep == 2'h0, 1'b1, ep, b, d};
         @(posedge clk) #1;
         engWr = 1'b0;
         engWrData = ~d;
         engCtrlRxDone = (ep == 2'h0);
         engEp2RxAccept = (ep == 2'h2);
         @(posedge clk) #1;
         {engBusy, engCtrlRxDone, engEp2RxAccept} = 3'h0;
      end
   endtask : put
   // serve a pending transmit: fetch a byte, then report it sent
   task send(input logic [1:0] ep);
      if (txRequest_ff[ep]) begin
         {engRd, engEp, engByte} = {1'b1, ep, 3'h0};
         @(posedge clk) #1;
         engRd = 1'b0;
         engTxDone = 3'h1 << ep;
         @(posedge clk) #1;
         engTxDone = 3'h0;
      end
   endtask : send
endmodule : uasir_eng_model
`default_nettype wire

//--- test/usb_app_status_int_regs_bench.sv
// self-checking bench for the status, fifo window, flag and control registers
// assumes uasir_pkg and the engine stand-in are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
   $display("MISMATCH %0t got %h want %h", $time, (a), (e)); end end
module usb_app_status_int_regs_bench;
   import uasir_pkg::*;
   localparam int SUSP = 20;
   localparam int WDT = 10;
   logic clk, rst_b, regWr, regRd, ctrlRegWrInstr, ctrlRegRdInstr, irqDisableInstr;
   logic irqEnableInstr, irqReturnInstr, supplyLowPin, usbMode, dualClock, timerOverflow;
   logic watchdogEnable, irqReq_ff, timerTick_ff, watchdogTimeout_ff, ledSinkEn_ff;
   logic engSetupOk, engBusy, engBusActivity, engEp2RxAccept, engCtrlRxDone, engCtrlCmd;
   logic engBusReset, engWr, engRd, stallReq_ff, ep2RxBlock_ff, ctrlRxLock_ff;
   logic [7:0] regAddr, regWrData, regRdData_ff, irqMask, engWrData, engRdData_ff;
   logic [3:0] port7PinsHi;
   logic [2:0] engTxDone, engByte, txRequest_ff;
   logic [1:0] engEp;
   logic [7:0] mem [EP_COUNT][FIFO_DEPTH];
   int err_count, n_tests, g;
   uasir_regs #(.SUSPEND_CYC(SUSP), .WDT_CYC(WDT)) i_uasir_regs (.*);
   uasir_eng_model i_uasir_eng_model (.*);
   initial clk = 1'b0;
   always #5 clk = ~clk;
   function int tmr(int s);
      return 2 ** (s + 1);
   endfunction : tmr
   function int wdt(int s);
      return WDT * (2 ** s);
   endfunction : wdt
   task tick(input int n);
      repeat (n) @(posedge clk) #1;
   endtask : tick
   // a spare cycle first, so a strobe is never dropped and raised in one step
   task wr(input logic c, input logic [7:0] a, input logic [7:0] d);
      tick(1);
      {ctrlRegWrInstr, regWr, regAddr, regWrData} = {c, !c, a, d};
      tick(1);
      {ctrlRegWrInstr, regWr} = 2'h0;
   endtask : wr
   task rd(input logic c, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      tick(1);
      {ctrlRegRdInstr, regRd, regAddr} = {c, !c, a};
      tick(1);
      {ctrlRegRdInstr, regRd} = 2'h0;
      `CHK(regRdData_ff & m, e)
   endtask : rd
   task seek(input int e, input logic [7:0] b);
      wr(0, ADDR_FIFO_PTR, {3'h0, PTR_WIN_BASE} + 8'(e));
      wr(0, ADDR_FIFO_DATA, b);
      wr(0, ADDR_FIFO_PTR, 8'(e));
   endtask : seek
   // second gap is measured: the first may start mid-count after a change
   task gap(input logic w, output int n);
      repeat (2) begin
         n = 0;
         do begin
            tick(1);
            n++;
         end while ((w ? watchdogTimeout_ff : timerTick_ff) !== 1'b1 && n < 3000);
      end
   endtask : gap
   task end_of_test();
      if (err_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #200us;
      err_count++;
      end_of_test();
   end
   initial begin
      {regWr, regRd, ctrlRegWrInstr, ctrlRegRdInstr, irqDisableInstr, irqEnableInstr} = '0;
      {irqReturnInstr, supplyLowPin, usbMode, dualClock, timerOverflow, watchdogEnable} = '0;
      {regAddr, regWrData, irqMask, port7PinsHi, err_count, n_tests} = '0;
      rst_b = 1'b0;
      void'($urandom(32'h8b9472d2));
      repeat (6) @(posedge clk);
      #1 rst_b = 1'b1;
      i_uasir_eng_model.ev(1);
      rd(0, ADDR_EP_STATUS, 8'hff, RST_ZERO);
      rd(0, ADDR_IRQ_FLAGS, 8'hff, RST_ZERO);
      rd(0, 8'h0b, 8'hff, RST_ZERO);
      rd(1, 8'h00, 8'hff, RST_CONTROL);
      wr(0, ADDR_FIFO_PTR, 8'hff);
      rd(0, ADDR_FIFO_PTR, 8'hff, 8'h1f);
      for (int e = 0; e < EP_COUNT; e++) begin
         seek(e, 8'h00);
         for (int b = 0; b < FIFO_DEPTH; b++) begin
            mem[e][b] = 8'($urandom);
            wr(0, ADDR_FIFO_DATA, mem[e][b]);
         end
         seek(e, 8'h00);
         for (int b = 0; b < FIFO_DEPTH; b++) rd(0, ADDR_FIFO_DATA, 8'hff, mem[e][b]);
         wr(0, ADDR_FIFO_PTR, {3'h0, PTR_WIN_BASE} + 8'(e));
         rd(0, ADDR_FIFO_DATA, 8'hff, 8'h00);
      end
      i_uasir_eng_model.put(0, 3'h3, 8'hc3);
      i_uasir_eng_model.put(0, 3'h3, 8'h3c);
      seek(0, 8'h03);
      rd(0, ADDR_FIFO_DATA, 8'hff, 8'hc3);
      i_uasir_eng_model.put(2, 3'h1, 8'h77);
      rd(0, ADDR_EP_STATUS, 8'h88, 8'h88);
      wr(0, ADDR_EP_STATUS, 8'h00);
      `CHK({ctrlRxLock_ff, ep2RxBlock_ff}, 2'h0)
      wr(0, ADDR_EP_STATUS, 8'h81);
      `CHK({ctrlRxLock_ff, stallReq_ff}, 2'h3)
      i_uasir_eng_model.ev(0);
      `CHK(stallReq_ff, 1'b0)
      wr(0, ADDR_EP_STATUS, 8'h70);
      `CHK(txRequest_ff, 3'h7)
      for (int e = 0; e < EP_COUNT; e++) begin
         i_uasir_eng_model.send(2'(e));
         `CHK(engRdData_ff, mem[e][0])
      end
      rd(0, ADDR_EP_STATUS, 8'h70, 8'h00);
      wr(0, ADDR_IRQ_FLAGS, 8'h00);
      irqMask = 8'h01 | (8'($urandom) & 8'h9e);
      timerOverflow = 1'b1;
      tick(1);
      timerOverflow = 1'b0;
      i_uasir_eng_model.ev(2);
      i_uasir_eng_model.ev(3);
      rd(0, ADDR_IRQ_FLAGS, 8'h6b, 8'h0b);
      for (int k = 0; k < 2; k++) begin
         irqDisableInstr = 1'b1;
         tick(1);
         irqDisableInstr = 1'b0;
         tick(2);
         `CHK(irqReq_ff, 1'b0)
         {irqEnableInstr, irqReturnInstr} = {k == 0, k == 1};
         tick(1);
         {irqEnableInstr, irqReturnInstr} = 2'h0;
         tick(2);
         `CHK(irqReq_ff, 1'b1)
      end
      irqMask = 8'h60;
      tick(2);
      `CHK(irqReq_ff, 1'b0)
      wr(0, ADDR_IRQ_FLAGS, 8'h00);
      rd(0, ADDR_IRQ_FLAGS, 8'h0b, 8'h00);
      i_uasir_eng_model.ev(1);
      rd(0, ADDR_EP_STATUS, 8'h04, 8'h00);
      tick(SUSP);
      rd(0, ADDR_EP_STATUS, 8'h04, 8'h04);
      dualClock = 1'b1;
      i_uasir_eng_model.ev(1);
      rd(0, ADDR_IRQ_FLAGS, 8'h84, 8'h84);
      {usbMode, port7PinsHi} = {1'b1, 2'h0, 2'($urandom)};
      tick(5);
      rd(0, ADDR_IRQ_FLAGS, 8'h10, 8'h00);
      port7PinsHi = 4'h5;
      tick(5);
      rd(0, ADDR_IRQ_FLAGS, 8'h10, 8'h10);
      wr(0, ADDR_IRQ_FLAGS, 8'h00);
      {usbMode, port7PinsHi} = {1'b0, 4'h4};
      tick(5);
      rd(0, ADDR_IRQ_FLAGS, 8'h10, 8'h10);
      supplyLowPin = 1'b1;
      tick(4);
      supplyLowPin = 1'b0;
      tick(4);
      rd(0, ADDR_SUPPLY_DIP, 8'hff, 8'h10);
      wr(0, ADDR_SUPPLY_DIP, 8'h00);
      rd(0, ADDR_SUPPLY_DIP, 8'hff, 8'h00);
      supplyLowPin = 1'b1;
      tick(4);
      {rst_b, supplyLowPin} = 2'h0;
      tick(1);
      rst_b = 1'b1;
      rd(0, ADDR_SUPPLY_DIP, 8'hff, 8'h00);
      watchdogEnable = 1'b1;
      for (int s = 0; s < 3; s++) begin
         wr(1, 8'h00, {1'(s), 1'b0, 3'(s), 3'(s)});
         gap(0, g);
         `CHK(g, tmr(s))
         gap(1, g);
         `CHK(g, wdt(s))
         `CHK(ledSinkEn_ff, 1'(s))
      end
      end_of_test();
   end
endmodule : usb_app_status_int_regs_bench
`default_nettype wire
